// [bench/testbench.sv]
// testbench: apb host driving the scan block against a display memory model
`timescale 1ns/1ps
`default_nettype none
`include "lcd_scan_defs.svh"
module testbench
    import lcd_scan_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] vram_addr, last_a;
    logic vram_rd, vram_wr, pix_valid, cg_second_byte, panel_lower, line_pause, cursor_here, cursor_block;
    logic [7:0] vram_wdata, vram_rdata, pix_byte;
    logic [3:0] cg_row;
    logic [2:0] pix_shift;
    logic [1:0] cursor_layer;
    logic [5:0] pq [$];
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    lcd_scan_cursor_scroll #(.AW(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vram_addr(vram_addr), .vram_rd(vram_rd), .vram_wr(vram_wr), .vram_wdata(vram_wdata),
        .vram_rdata(vram_rdata), .pix_byte(pix_byte), .pix_valid(pix_valid), .cg_row(cg_row),
        .cg_second_byte(cg_second_byte), .panel_lower(panel_lower), .line_pause(line_pause),
        .pix_shift(pix_shift), .cursor_here(cursor_here), .cursor_block(cursor_block),
        .cursor_layer(cursor_layer));
    vram_model mem_model (.clk(pclk), .addr(vram_addr), .rd(vram_rd), .wr(vram_wr), .wdata(vram_wdata),
        .rdata(vram_rdata));
    // ----------------------------------------
    // clock, reset, watchdog
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #200_000;
        fail_count++;
        print_verdict();
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one setup edge, then hold until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_rd(output logic [15:0] a, output int t);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (vram_rd !== 1'b1 && n < 200);
        a = vram_addr;
        t = cyc;
    endtask : wait_rd
    task automatic watch_cursor(input logic [15:0] at, output int hits);
        hits = 0;
        repeat (4000) begin
            @(posedge pclk);
            if (cursor_here === 1'b1) begin
                hits++;
                check("cursor addr", {16'h0, at}, {16'h0, vram_addr});
            end
        end
    endtask : watch_cursor
    // scan reads only; host reads fall in the pause
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (vram_rd === 1'b1 && line_pause === 1'b0) begin
            last_a <= vram_addr;
        end
        if (pix_valid === 1'b1) begin
            check("pix_byte", {24'h0, last_a[7:0] ^ last_a[15:8] ^ 8'hA5}, {24'h0, pix_byte});
            pq.push_back({cg_second_byte, panel_lower, cg_row});
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic reset_values();
        logic [11:0] ofs [6] = '{`OFS_CTRL, `OFS_LINE_RANGE, `OFS_TOTAL_LINE, `OFS_PITCH, `OFS_FIELD,
            `OFS_FRAME_LINES};
        logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_0027, 32'h0000_002F, 32'h0000_0028, 32'h0000_0077,
            32'h0000_003F};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ofs[i], 32'h0000_0000);
            check("reset value", rv[i], rd);
        end
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        check("unmapped write err", 32'h0000_0001, {31'h0, err});
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        check("unmapped read data", 32'h0000_0000, rd);
        $display("reset_values done");
    endtask : reset_values
    // three lines of four reads, line range 3, total length 5, pitch 0x10
    task automatic scan_check(input logic [7:0] ctrl, input logic [7:0] field, input logic [47:0] st,
        input logic [14:0] tg, input bit wide = 1'b0);
        logic [15:0] a;
        int t, tp;
        apb(1'b1, `OFS_CTRL, 32'h0000_0000);
        apb(1'b1, `OFS_LINE_RANGE, 32'h0000_0003);
        apb(1'b1, `OFS_TOTAL_LINE, 32'h0000_0005);
        apb(1'b1, `OFS_PITCH, 32'h0000_0010);
        apb(1'b1, `OFS_FIELD, {24'h0, field});
        apb(1'b1, `OFS_SAD_FIRST, 32'h0000_0100);
        apb(1'b1, `OFS_SAD_THIRD, 32'h0000_0800);
        pq.delete();
        apb(1'b1, `OFS_CTRL, {24'h0, ctrl});
        tp = 0;
        for (int i = 0; i < 12; i++) begin
            wait_rd(a, t);
            check("scan addr", st[47 - 16 * (i / 4) -: 16] + (wide ? (i % 4) / 2 : i % 4), {16'h0, a});
            if (i > 0) check("read spacing", (i % 4 == 0) ? 27 : 9, t - tp);
            tp = t;
        end
        repeat (12) @(posedge pclk);
        for (int l = 0; l < 3; l++) begin
            check("row panel", {27'h0, tg[14 - 5 * l -: 5]}, {26'h0, pq[4 * l]});
            check("second byte", {31'h0, wide}, {31'h0, pq[4 * l + 1][5]});
        end
        $display("scan_check %h done", ctrl);
    endtask : scan_check
    task automatic host_access();
        logic [31:0] saved;
        int n;
        apb(1'b0, `OFS_CURSOR, 32'h0000_0000);
        saved = rd;
        apb(1'b1, `OFS_CURDIR, {30'h0, DIR_DOWN});
        apb(1'b1, `OFS_CURSOR, 32'h0000_8000);
        apb(1'b1, `OFS_MEMWR, 32'h0000_003C);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (vram_wr !== 1'b1 && n < 200);
        check("write addr", 32'h0000_8000, {16'h0, vram_addr});
        check("write data", 32'h0000_003C, {24'h0, vram_wdata});
        check("write in pause", 32'h0000_0001, {31'h0, line_pause});
        repeat (3) @(posedge pclk);
        apb(1'b0, `OFS_CURSOR, 32'h0000_0000);
        check("cursor down", 32'h0000_8010, rd);
        apb(1'b1, `OFS_CURDIR, {30'h0, DIR_RIGHT});
        apb(1'b1, `OFS_CURSOR, 32'h0000_8000);
        apb(1'b1, `OFS_MEMRD, 32'h0000_0000);
        n = 0;
        do begin
            apb(1'b0, `OFS_STATUS, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        apb(1'b0, `OFS_MEMRD, 32'h0000_0000);
        check("read back", 32'h0000_003C, rd);
        apb(1'b0, `OFS_CURSOR, 32'h0000_0000);
        check("cursor right", 32'h0000_8001, rd);
        apb(1'b1, `OFS_MEMWR, 32'h0000_0000);
        do begin
            apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        end while (rd[0] !== 1'b0);
        apb(1'b1, `OFS_CURSOR, saved);
        $display("host_access done");
    endtask : host_access
    task automatic cursor_shape();
        int hits;
        apb(1'b1, `OFS_HSCROLL, 32'h0000_0005);
        apb(1'b1, `OFS_CTRL, 32'h0000_008B);
        repeat (20) @(posedge pclk);
        check("pixel shift", 32'h0000_0005, {29'h0, pix_shift});
        check("layer three", 32'h0000_0002, {30'h0, cursor_layer});
        apb(1'b1, `OFS_CURSOR, 32'h0000_0102);
        apb(1'b1, `OFS_CTRL, 32'h0000_00A3);
        watch_cursor(16'h0102, hits);
        check("cursor shown", 32'h0000_0001, {31'h0, hits > 0});
        check("layer first", 32'h0000_0000, {30'h0, cursor_layer});
        check("bar without text", 32'h0000_0000, {31'h0, cursor_block});
        apb(1'b1, `OFS_AREA_BASE, 32'h0000_0200);
        watch_cursor(16'h0102, hits);
        check("cursor hidden", 32'h0000_0000, hits);
        apb(1'b1, `OFS_AREA_BASE, 32'h0000_0000);
        apb(1'b1, `OFS_SAD_SECOND, 32'h0000_4000);
        apb(1'b1, `OFS_CTRL, 32'h0000_00F3);
        repeat (4000) @(posedge pclk);
        check("block on text", 32'h0000_0001, {31'h0, cursor_block});
        apb(1'b1, `OFS_CURSOR, 32'h0000_4002);
        repeat (4000) @(posedge pclk);
        check("bar on graphics", 32'h0000_0000, {31'h0, cursor_block});
        $display("cursor_shape done");
    endtask : cursor_shape
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        scan_check(8'h03, 8'h77, {16'h0100, 16'h0110, 16'h0120}, 15'h0000);
        scan_check(8'h11, 8'h17, {16'h0100, 16'h0100, 16'h0110}, {5'h00, 5'h01, 5'h00});
        scan_check(8'h11, 8'h18, {16'h0100, 16'h0100, 16'h0110}, {5'h00, 5'h01, 5'h00}, 1'b1);
        scan_check(8'h07, 8'h77, {16'h0100, 16'h0800, 16'h0110}, {5'h00, 5'h10, 5'h00});
        host_access();
        cursor_shape();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire

// [bench/vram_model.sv]
// display memory model answering the scan block's read and write strobes
`timescale 1ns/1ps
`default_nettype none
module vram_model
    import lcd_scan_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] held;
    int age;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
        end
        age = 99;
        held = 8'h00;
    end
    always @(posedge clk) begin
        if (wr === 1'b1) begin
            mem[addr] <= wdata;
        end
        if (rd === 1'b1) begin
            held <= mem[addr];
            age <= 0;
        end else if (age < 99) begin
            age <= age + 1;
        end
    end
    // slow memory: data lands a cycle late and is gone after the sample point
    assign rdata = (age >= 1 && age <= 7) ? held : ~held;
endmodule : vram_model
`default_nettype wire

// [core/lcd_scan_cursor_scroll.sv]
// display scan, cursor and scroll control with an apb register file
//
// Behaviour
// - bitmap origin top left; adjacent byte bits are adjacent pixels left to right.
// - displayed field width and height set by registers, not the bitmap.
// - field width up to 16; wider than 8 fetches two bytes per row.
// - memory read in raster order, left to right, rows top to bottom.
// - graphics mode: next line start is previous start plus address pitch.
// - text mode: same start per bitmap row, next row; after last, add pitch.
// - two-panel: upper and lower lines fetched alternately as one cycle.
// - each read cycle is nine clocks; line range plus one reads per line.
// - end-of-line pause of total length minus line range cycles; drive continues.
// - host memory access is done during the end-of-line pause.
// - one cursor address serves display cursor and host access address.
// - cursor address steps by the chosen direction after every memory access.
// - cursor on first layer with two layers, third layer with three.
// - cursor hidden while its address lies outside its layer area.
// - without a text screen only a bar cursor is shown.
// - mixed first layer with block shape: block over text, bar over graphics.
// - a layer window splits into two blocks with own start addresses.
// - character step scroll via start address, pixel step via shift register.
// - pixel shift applies to the whole layer; text vertical in characters.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_scan_defs.svh"
module lcd_scan_cursor_scroll
    import lcd_scan_pkg::*;
#(
    parameter int AW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [AW-1:0] vram_addr,
    output logic vram_rd,
    output logic vram_wr,
    output logic [7:0] vram_wdata,
    input wire logic [7:0] vram_rdata,
    output logic [7:0] pix_byte,
    output logic pix_valid,
    output logic [3:0] cg_row,
    output logic cg_second_byte,
    output logic panel_lower,
    output logic line_pause,
    output logic [2:0] pix_shift,
    output logic cursor_here,
    output logic cursor_block,
    output logic [1:0] cursor_layer
);
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] ctrl_r, line_range_r, total_line_r, field_r;
    logic [AW-1:0] pitch_r, scroll_start_first_r, sad2_r, sad3_r, cursor_r, area_base_r, area_len_r;
    logic [9:0] frame_lines_r, block1_lines_r;
    logic [1:0] curdir_r;
    logic [2:0] hscroll_r;
    logic [7:0] wdata_r, rdata_r;
    logic host_busy_r;
    host_op_t host_op_r;
    logic [3:0] div_r;
    logic [7:0] cyc_r;
    logic [7:0] col_r;
    logic byte_sel_r;
    logic [3:0] row_r;
    logic [9:0] line_no_r;
    logic [AW-1:0] upper_start_r, lower_start_r;
    logic panel_r;
    logic in_block2_r;
    logic scan_rd_r, host_done_r, host_rd_pend_r;

    logic wr_en, rd_en, mapped, cyc_end, line_end, in_pause, host_go, wide;
    logic [AW-1:0] step;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign wide = field_r[3];
    assign cyc_end = ctrl_r[`CTRL_ENABLE] && (div_r == `CYCLE_CLKS - 4'h1);
    assign line_end = cyc_end && (cyc_r == total_line_r);
    assign in_pause = cyc_r > line_range_r;
    assign host_go = host_busy_r && in_pause && ctrl_r[`CTRL_ENABLE] && (div_r == 4'h0);

    always_comb begin
        mapped = 1'b1;
        prdata = 32'h0000_0000;
        case (paddr)
            `OFS_CTRL: prdata = {24'h00_0000, ctrl_r};
            `OFS_LINE_RANGE: prdata = {24'h00_0000, line_range_r};
            `OFS_TOTAL_LINE: prdata = {24'h00_0000, total_line_r};
            `OFS_PITCH: prdata = {16'h0000, pitch_r};
            `OFS_FIELD: prdata = {24'h00_0000, field_r};
            `OFS_FRAME_LINES: prdata = {22'h00_0000, frame_lines_r};
            `OFS_BLOCK1_LINES: prdata = {22'h00_0000, block1_lines_r};
            `OFS_SAD_FIRST: prdata = {16'h0000, scroll_start_first_r};
            `OFS_SAD_SECOND: prdata = {16'h0000, sad2_r};
            `OFS_SAD_THIRD: prdata = {16'h0000, sad3_r};
            `OFS_CURSOR: prdata = {16'h0000, cursor_r};
            `OFS_CURDIR: prdata = {30'h0000_0000, curdir_r};
            `OFS_HSCROLL: prdata = {29'h0000_0000, hscroll_r};
            `OFS_MEMWR: prdata = {24'h00_0000, wdata_r};
            `OFS_MEMRD: prdata = {24'h00_0000, rdata_r};
            `OFS_STATUS: prdata = {line_no_r, 2'b00, row_r, cyc_r, 6'h00, panel_r, host_busy_r || host_rd_pend_r};
            `OFS_AREA_BASE: prdata = {16'h0000, area_base_r};
            `OFS_AREA_LEN: prdata = {16'h0000, area_len_r};
            default: begin
                mapped = 1'b0;
            end
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RST;
            line_range_r <= `LINE_RANGE_RST;
            total_line_r <= `TOTAL_LINE_RST;
            pitch_r <= `PITCH_RST;
            field_r <= `FIELD_RST;
            frame_lines_r <= `FRAME_LINES_RST;
            block1_lines_r <= `FRAME_LINES_RST;
            scroll_start_first_r <= '0;
            sad2_r <= '0;
            sad3_r <= '0;
            curdir_r <= DIR_RIGHT;
            hscroll_r <= 3'h0;
            area_base_r <= '0;
            area_len_r <= '1;
        end else if (wr_en) begin
            case (paddr)
                `OFS_CTRL: ctrl_r <= pwdata[7:0];
                `OFS_LINE_RANGE: line_range_r <= pwdata[7:0];
                `OFS_TOTAL_LINE: total_line_r <= pwdata[7:0];
                `OFS_PITCH: pitch_r <= pwdata[AW-1:0];
                `OFS_FIELD: field_r <= pwdata[7:0];
                `OFS_FRAME_LINES: frame_lines_r <= pwdata[9:0];
                `OFS_BLOCK1_LINES: block1_lines_r <= pwdata[9:0];
                `OFS_SAD_FIRST: scroll_start_first_r <= pwdata[AW-1:0];
                `OFS_SAD_SECOND: sad2_r <= pwdata[AW-1:0];
                `OFS_SAD_THIRD: sad3_r <= pwdata[AW-1:0];
                `OFS_CURDIR: curdir_r <= pwdata[1:0];
                `OFS_HSCROLL: hscroll_r <= pwdata[2:0];
                `OFS_AREA_BASE: area_base_r <= pwdata[AW-1:0];
                `OFS_AREA_LEN: area_len_r <= pwdata[AW-1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // host access through the cursor address
    // ------------------------------------------------------------
    always_comb begin
        case (curdir_r)
            DIR_RIGHT: step = {{(AW-1){1'b0}}, 1'b1};
            DIR_LEFT: step = '1;
            DIR_UP: step = AW'(~pitch_r + 1'b1);
            default: step = pitch_r;
        endcase
    end

    // a new request while busy is dropped; software polls the busy bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_busy_r <= 1'b0;
            host_op_r <= HOST_IDLE;
            wdata_r <= 8'h00;
        end else if (host_go) begin
            host_busy_r <= 1'b0;
            host_op_r <= HOST_IDLE;
        end else if (wr_en && !host_busy_r && (paddr == `OFS_MEMWR || paddr == `OFS_MEMRD)) begin
            host_busy_r <= 1'b1;
            host_op_r <= (paddr == `OFS_MEMWR) ? HOST_WR : HOST_RD;
            if (paddr == `OFS_MEMWR) begin
                wdata_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cursor_r <= '0;
        end else if (host_done_r) begin
            cursor_r <= cursor_r + step;
        end else if (wr_en && paddr == `OFS_CURSOR) begin
            cursor_r <= pwdata[AW-1:0];
        end
    end

    // ------------------------------------------------------------
    // read cycle timing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 4'h0;
            cyc_r <= 8'h00;
        end else if (!ctrl_r[`CTRL_ENABLE]) begin
            div_r <= 4'h0;
            cyc_r <= 8'h00;
        end else if (cyc_end) begin
            div_r <= 4'h0;
            cyc_r <= line_end ? 8'h00 : cyc_r + 8'h01;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // scan addressing
    // ------------------------------------------------------------
    logic frame_end, block_switch, last_row, advance;
    assign frame_end = line_end && (line_no_r == frame_lines_r);
    assign block_switch = line_end && !in_block2_r && (line_no_r + 10'h001 == block1_lines_r);
    assign last_row = ctrl_r[`CTRL_GRAPHICS] || (row_r == field_r[7:4]);
    assign advance = !ctrl_r[`CTRL_TWO_PANEL] || panel_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_r <= 8'h00;
            byte_sel_r <= 1'b0;
        end else if (line_end || !ctrl_r[`CTRL_ENABLE]) begin
            col_r <= 8'h00;
            byte_sel_r <= 1'b0;
        end else if (cyc_end && !in_pause) begin
            byte_sel_r <= wide && !byte_sel_r;
            col_r <= (wide && !byte_sel_r) ? col_r : col_r + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_r <= 4'h0;
            line_no_r <= 10'h000;
            upper_start_r <= '0;
            lower_start_r <= '0;
            panel_r <= 1'b0;
            in_block2_r <= 1'b0;
        end else if (frame_end || !ctrl_r[`CTRL_ENABLE]) begin
            row_r <= 4'h0;
            line_no_r <= 10'h000;
            upper_start_r <= scroll_start_first_r;
            lower_start_r <= sad3_r;
            panel_r <= 1'b0;
            in_block2_r <= 1'b0;
        end else if (line_end) begin
            panel_r <= ctrl_r[`CTRL_TWO_PANEL] && !panel_r;
            if (advance) begin
                line_no_r <= line_no_r + 10'h001;
                if (block_switch) begin
                    upper_start_r <= sad2_r;
                    in_block2_r <= 1'b1;
                    row_r <= 4'h0;
                end else if (last_row) begin
                    upper_start_r <= upper_start_r + pitch_r;
                    lower_start_r <= lower_start_r + pitch_r;
                    row_r <= 4'h0;
                end else begin
                    row_r <= row_r + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // memory port
    // ------------------------------------------------------------
    logic scan_go;
    logic [AW-1:0] scan_addr;
    assign scan_go = ctrl_r[`CTRL_ENABLE] && !in_pause && (div_r == 4'h0);
    assign scan_addr = (panel_r ? lower_start_r : upper_start_r) + AW'(col_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vram_addr <= '0;
            vram_rd <= 1'b0;
            vram_wr <= 1'b0;
            vram_wdata <= 8'h00;
            scan_rd_r <= 1'b0;
        end else begin
            vram_rd <= scan_go || (host_go && host_op_r == HOST_RD);
            vram_wr <= host_go && host_op_r == HOST_WR;
            scan_rd_r <= scan_go;
            if (scan_go) begin
                vram_addr <= scan_addr;
            end else if (host_go) begin
                vram_addr <= cursor_r;
                vram_wdata <= wdata_r;
            end
        end
    end

    // scan data is taken at the cycle's last clock, so memory gets eight clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_byte <= 8'h00;
            pix_valid <= 1'b0;
            cg_row <= 4'h0;
            cg_second_byte <= 1'b0;
            panel_lower <= 1'b0;
            rdata_r <= 8'h00;
            host_rd_pend_r <= 1'b0;
            host_done_r <= 1'b0;
        end else begin
            host_done_r <= host_go;
            pix_valid <= cyc_end && !in_pause;
            if (host_go) begin
                host_rd_pend_r <= host_op_r == HOST_RD;
            end else if (cyc_end) begin
                host_rd_pend_r <= 1'b0;
            end
            if (cyc_end && !in_pause) begin
                pix_byte <= vram_rdata;
                cg_row <= row_r;
                cg_second_byte <= byte_sel_r;
                panel_lower <= panel_r;
            end
            if (cyc_end && host_rd_pend_r) begin
                rdata_r <= vram_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // cursor display and pixel shift
    // ------------------------------------------------------------
    logic cur_in_area;
    assign cur_in_area = (cursor_r >= area_base_r) && ((cursor_r - area_base_r) < area_len_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cursor_here <= 1'b0;
            cursor_block <= 1'b0;
            cursor_layer <= 2'b00;
            line_pause <= 1'b0;
            pix_shift <= 3'h0;
        end else begin
            line_pause <= ctrl_r[`CTRL_ENABLE] && in_pause;
            pix_shift <= hscroll_r;
            cursor_layer <= ctrl_r[`CTRL_THREE_LAYER] ? 2'b10 : 2'b00;
            cursor_here <= scan_go && ctrl_r[`CTRL_CURSOR_ON] && cur_in_area && scan_addr == cursor_r;
            cursor_block <= ctrl_r[`CTRL_TEXT_ON] && ctrl_r[`CTRL_BLOCK_SHAPE]
                && !(ctrl_r[`CTRL_MIXED] && cursor_r >= sad2_r);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_div_range: assert property (div_r < `CYCLE_CLKS) else $error("divider out of range");
    chk_read_spacing: assert property (vram_rd |=> !vram_rd [*8]) else $error("reads closer than nine clocks");
    chk_scan_not_pause: assert property (scan_rd_r |-> !line_pause) else $error("scan read during pause");
    chk_host_in_pause: assert property ((vram_wr || (vram_rd && !scan_rd_r)) |-> line_pause)
        else $error("host access outside pause");
    chk_host_addr: assert property (host_go |=> vram_addr == $past(cursor_r))
        else $error("host access not at cursor");
    chk_cursor_step: assert property (host_go |=> ##1 cursor_r == $past(cursor_r, 2) + $past(step, 2))
        else $error("cursor not stepped");
    chk_graphic_line: assert property (line_end && ctrl_r[`CTRL_GRAPHICS] && !ctrl_r[`CTRL_TWO_PANEL]
        && !frame_end && !block_switch && !$changed(pitch_r)
        |=> upper_start_r == $past(upper_start_r) + pitch_r) else $error("graphics line start wrong");
    chk_text_row: assert property (line_end && !last_row && !frame_end && !block_switch && advance
        |=> $stable(upper_start_r) && row_r == $past(row_r) + 4'h1) else $error("text row reuse wrong");
    chk_panel_swap: assert property (line_end && !frame_end && ctrl_r[`CTRL_TWO_PANEL] |=> panel_r != $past(panel_r))
        else $error("panels not alternating");
    chk_cursor_hide: assert property (cursor_here |-> $past(cur_in_area)) else $error("cursor outside area");
    chk_bar_only: assert property (!$past(ctrl_r[`CTRL_TEXT_ON]) |-> !cursor_block)
        else $error("block cursor without text");
    cov_host_write: cover property (host_go && host_op_r == HOST_WR);
    cov_two_panel: cover property (line_end && panel_r);
    cov_frame_end: cover property (frame_end);
    cov_wide_char: cover property (pix_valid && cg_second_byte);
endmodule : lcd_scan_cursor_scroll
`default_nettype wire

// [core/lcd_scan_defs.svh]
// register offsets, field positions, reset values and timing counts of the scan block
`ifndef LCD_SCAN_DEFS_SVH
`define LCD_SCAN_DEFS_SVH
`define OFS_CTRL 12'h000
`define OFS_LINE_RANGE 12'h004
`define OFS_TOTAL_LINE 12'h008
`define OFS_PITCH 12'h00C
`define OFS_FIELD 12'h010
`define OFS_FRAME_LINES 12'h014
`define OFS_BLOCK1_LINES 12'h018
`define OFS_SAD_FIRST 12'h01C
`define OFS_SAD_SECOND 12'h020
`define OFS_SAD_THIRD 12'h024
`define OFS_CURSOR 12'h028
`define OFS_CURDIR 12'h02C
`define OFS_HSCROLL 12'h030
`define OFS_MEMWR 12'h034
`define OFS_MEMRD 12'h038
`define OFS_STATUS 12'h03C
`define OFS_AREA_BASE 12'h040
`define OFS_AREA_LEN 12'h044
`define CTRL_ENABLE 0
`define CTRL_GRAPHICS 1
`define CTRL_TWO_PANEL 2
`define CTRL_THREE_LAYER 3
`define CTRL_TEXT_ON 4
`define CTRL_BLOCK_SHAPE 5
`define CTRL_MIXED 6
`define CTRL_CURSOR_ON 7
`define CTRL_RST 8'h00
`define LINE_RANGE_RST 8'h27
`define TOTAL_LINE_RST 8'h2F
`define PITCH_RST 16'h0028
`define FIELD_RST 8'h77
`define FRAME_LINES_RST 10'h03F
`define CYCLE_CLKS 4'h9
`endif

// [core/lcd_scan_pkg.sv]
// types shared by the scan block
package lcd_scan_pkg;
    typedef enum logic [1:0] {
        DIR_RIGHT = 2'b00,
        DIR_LEFT = 2'b01,
        DIR_UP = 2'b10,
        DIR_DOWN = 2'b11
    } cur_dir_t;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_WR = 2'b01,
        HOST_RD = 2'b10
    } host_op_t;
endpackage : lcd_scan_pkg
